// *** ctm_timer.sv ***
// Functional notes
// - Mode field: 00 compare-match, 10 PWM, 11 timer/counter.
// - Clear-select low: clear on P match, overflow if period zero; both flags raised.
// - Clear-select high: clear on A match; only A flag, never P flag.
// - Clear-select high and compare A zero: overflow at 3FF, no A flag.
// - Compare-match mode: pin changes only on A match, never on P match.
// - A match drives pin high, low or toggles per pin action; zero means none.
// - Enable rising edge sets pin to the output-control initial level.
// - Timer/counter mode counts and flags like compare-match, pin unused.
// - PWM mode ignores clear-select; swap bit alone picks the clearing comparator.
// - PWM: one comparator sets period by clearing, the other sets duty.
// - PWM raises A flag on every A match, P flag on every P match.
// - PWM: output-control gives polarity; pin action enables or forces the pin.
// - Polarity-invert bit inverts the final output.
// - Swap 0: period is period value times 128, or 1024; duty compare A.
// - Duty at or above period gives 100 percent duty.
// - Swap 1: period from compare A; duty period value times 128, or 1024.
// - PWM counting continues while pin action forces the pin.
// - Enable rise zeroes counter; enable fall stops and holds count.
// - Period value compared with next-count bits 9 to 7; bits 6 to 0 must be zero.
// - PWM output-control 0 is active low, 1 active high.
`timescale 1ns/10ps
`include "ctm_cfg.svh"

module ctm_timer #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Optional timer clock sources
   input  wire logic              sub_clk_in,
   input  wire logic              ext_clk_in,
   // Output pin
   output logic                   timer_output_pin
);

   // ==========================================================================
   // Register bus front end
   // ==========================================================================
   logic              reg_wr;
   logic [ADDR_W-1:0] reg_waddr;
   logic [31:0]       reg_wdata;
   logic [3:0]        reg_wstrb;
   logic [ADDR_W-1:0] reg_raddr;
   logic [31:0]       reg_rdata;
   logic              reg_werr;
   logic              reg_rerr;

   ctm_axil_slave #(
      .ADDR_W (ADDR_W)
   ) u_bus (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .reg_wr        (reg_wr),
      .reg_waddr     (reg_waddr),
      .reg_wdata     (reg_wdata),
      .reg_wstrb     (reg_wstrb),
      .reg_werr      (reg_werr),
      .reg_raddr     (reg_raddr),
      .reg_rdata     (reg_rdata),
      .reg_rerr      (reg_rerr)
   );

   // ==========================================================================
   // Address decode
   // ==========================================================================
   wire wsel_c0   = reg_wr & (reg_waddr == `CTM_OFF_CTRL0);
   wire wsel_c1   = reg_wr & (reg_waddr == `CTM_OFF_CTRL1);
   wire wsel_cmpa = reg_wr & (reg_waddr == `CTM_OFF_CMPA);
   wire wsel_st   = reg_wr & (reg_waddr == `CTM_OFF_STATUS);
   wire wsel_cnt  = reg_waddr == `CTM_OFF_COUNT;

   // The counter register is read only; a write to it is accepted and ignored.
   assign reg_werr = ~(wsel_c0 | wsel_c1 | wsel_cmpa | wsel_st | wsel_cnt);
   assign reg_rerr = ~((reg_raddr == `CTM_OFF_CTRL0) | (reg_raddr == `CTM_OFF_CTRL1)
                     | (reg_raddr == `CTM_OFF_COUNT) | (reg_raddr == `CTM_OFF_CMPA)
                     | (reg_raddr == `CTM_OFF_STATUS));

   // ==========================================================================
   // Control registers
   // ==========================================================================
   logic [7:0]            ctrl0;
   logic [7:0]            ctrl1;
   logic [`CTM_CNT_W-1:0] cmpa;
   logic                  match_a_flag;
   logic                  match_p_flag;
   logic [`CTM_CNT_W-1:0] count;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl0 <= `CTM_CTRL0_RST;
         ctrl1 <= `CTM_CTRL1_RST;
         cmpa  <= `CTM_CMPA_RST;
      end
      else
      begin
         if (wsel_c0 & reg_wstrb[0])
            ctrl0 <= reg_wdata[7:0];
         if (wsel_c1 & reg_wstrb[0])
            ctrl1 <= reg_wdata[7:0];
         if (wsel_cmpa & reg_wstrb[0])
            cmpa[7:0] <= reg_wdata[7:0];
         if (wsel_cmpa & reg_wstrb[1])
            cmpa[9:8] <= reg_wdata[9:8];
      end
   end

   wire [`CTM_PER_W-1:0]  period_value     = ctrl0[`CTM_C0_PERIOD_LSB +: `CTM_PER_W];
   wire                   counter_enable   = ctrl0[`CTM_C0_ENABLE];
   wire [2:0]             clk_sel          = ctrl0[`CTM_C0_CLKSEL_LSB +: 3];
   wire                   clear_select     = ctrl1[`CTM_C1_CLRSEL];
   wire                   duty_period_swap = ctrl1[`CTM_C1_SWAP];
   wire                   polarity_invert  = ctrl1[`CTM_C1_POLINV];
   wire                   output_control   = ctrl1[`CTM_C1_OUTCTL];
   wire [1:0]             pin_action       = ctrl1[`CTM_C1_ACTION_LSB +: 2];
   wire [1:0]             mode_select      = ctrl1[`CTM_C1_MODE_LSB +: 2];

   assign reg_rdata = (reg_raddr == `CTM_OFF_CTRL0)  ? {24'h000000, ctrl0} :
                      (reg_raddr == `CTM_OFF_CTRL1)  ? {24'h000000, ctrl1} :
                      (reg_raddr == `CTM_OFF_COUNT)  ? {22'h000000, count} :
                      (reg_raddr == `CTM_OFF_CMPA)   ? {22'h000000, cmpa}  :
                      (reg_raddr == `CTM_OFF_STATUS) ? {30'h00000000, match_p_flag,
                                                        match_a_flag} :
                      32'h00000000;

   // ==========================================================================
   // Timer clock selection
   // ==========================================================================
   // Pins are synchronised before edge detection; this limits the pin clock
   // to well under half of aclk.
   logic [2:0] sub_sync;
   logic [2:0] ext_sync;
   logic [5:0] prescale;
   logic       en_d;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sub_sync <= 3'h0;
         ext_sync <= 3'h0;
         prescale <= 6'h00;
         en_d     <= 1'b0;
      end
      else
      begin
         sub_sync <= {sub_sync[1:0], sub_clk_in};
         ext_sync <= {ext_sync[1:0], ext_clk_in};
         prescale <= prescale + 6'h01;
         en_d     <= counter_enable;
      end
   end

   logic tick;
   always_comb
   begin
      unique case (ctm_pkg::ctm_clksel_t'(clk_sel))
         ctm_pkg::CTM_CLK_DIV4:  tick = (prescale[1:0] == 2'(`CTM_DIV_4));
         ctm_pkg::CTM_CLK_DIV1:  tick = 1'b1;
         ctm_pkg::CTM_CLK_DIV16: tick = (prescale[3:0] == 4'(`CTM_DIV_16));
         ctm_pkg::CTM_CLK_DIV64: tick = (prescale == `CTM_DIV_64);
         ctm_pkg::CTM_CLK_SUB_A,
         ctm_pkg::CTM_CLK_SUB_B: tick = sub_sync[1] & ~sub_sync[2];
         ctm_pkg::CTM_CLK_EXT_R: tick = ext_sync[1] & ~ext_sync[2];
         ctm_pkg::CTM_CLK_EXT_F: tick = ~ext_sync[1] & ext_sync[2];
      endcase
   end

   // ==========================================================================
   // Counter and comparators
   // ==========================================================================
   // A match is taken at the tick that would carry the counter onto the
   // compare value; the counter then clears instead, so a value N gives a
   // cycle of N ticks.
   wire                   enable_rise = counter_enable & ~en_d;
   wire                   step        = counter_enable & ~enable_rise & tick;
   wire [`CTM_CNT_W:0]    inc         = {1'b0, count} + 11'h001;
   wire                   overflow    = inc[`CTM_CNT_W];
   wire                   mode_pwm    = mode_select == ctm_pkg::CTM_MODE_PWM;
   wire                   mode_cmp    = mode_select == ctm_pkg::CTM_MODE_CMP;
   wire                   mode_tmr    = mode_select == ctm_pkg::CTM_MODE_TMR;

   // Period zero stands for the full 1024-count span.
   wire p_hit = (period_value == 3'h0) ? overflow
                : (inc[9:`CTM_PER_SHIFT] == period_value)
                  & (inc[`CTM_PER_SHIFT-1:0] == 7'h00) & ~overflow;
   wire a_hit = inc == {1'b0, cmpa};                      // Compare A zero never hits

   // Duty in ticks for the swapped PWM case.
   wire [`CTM_CNT_W:0] p_ticks = (period_value == 3'h0) ? 11'h400
                                 : {1'b0, period_value, 7'h00};
   wire [`CTM_CNT_W:0] duty    = duty_period_swap ? p_ticks : {1'b0, cmpa};

   logic clr;
   always_comb
   begin
      if (mode_pwm)
         clr = duty_period_swap ? (a_hit | overflow) : p_hit;
      else if (clear_select)
         clr = a_hit | overflow;
      else
         clr = p_hit;
   end

   wire set_a = step & a_hit;
   wire set_p = step & p_hit & (mode_pwm | ~clear_select);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count <= 10'h000;
      else if (enable_rise)
         count <= 10'h000;
      else if (step)
         count <= clr ? 10'h000 : inc[`CTM_CNT_W-1:0];
   end

   // ==========================================================================
   // Match flags
   // ==========================================================================
   // A new match in the same cycle as a write-one clear keeps the flag set.
   wire clr_a = wsel_st & reg_wstrb[0] & reg_wdata[`CTM_ST_FLAG_A];
   wire clr_p = wsel_st & reg_wstrb[0] & reg_wdata[`CTM_ST_FLAG_P];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         match_a_flag <= 1'b0;
         match_p_flag <= 1'b0;
      end
      else
      begin
         match_a_flag <= set_a | (match_a_flag & ~clr_a);
         match_p_flag <= set_p | (match_p_flag & ~clr_p);
      end
   end

   // ==========================================================================
   // Output pin
   // ==========================================================================
   logic cmp_level;
   logic pwm_active;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmp_level  <= 1'b0;
         pwm_active <= 1'b0;
      end
      else if (enable_rise)
      begin
         cmp_level  <= output_control;
         pwm_active <= duty != 11'h000;
      end
      else if (step)
      begin
         if (mode_cmp & a_hit)
         begin
            unique case (ctm_pkg::ctm_action_t'(pin_action))
               ctm_pkg::CTM_ACT_HOLD:   cmp_level <= cmp_level;
               ctm_pkg::CTM_ACT_LOW:    cmp_level <= 1'b0;
               ctm_pkg::CTM_ACT_HIGH:   cmp_level <= 1'b1;
               ctm_pkg::CTM_ACT_TOGGLE: cmp_level <= ~cmp_level;
            endcase
         end
         // Clear wins over a duty match in the same tick: 100 percent duty.
         if (clr)
            pwm_active <= duty != 11'h000;
         else if (inc == duty)
            pwm_active <= 1'b0;
      end
   end

   // Output-control is the active level in PWM mode; 11 is unused and idles.
   logic pwm_level;
   always_comb
   begin
      unique case (ctm_pkg::ctm_action_t'(pin_action))
         ctm_pkg::CTM_ACT_LOW:  pwm_level = output_control;
         ctm_pkg::CTM_ACT_HIGH: pwm_level = pwm_active ? output_control
                                                       : ~output_control;
         default:               pwm_level = ~output_control;
      endcase
   end

   wire pin_raw = mode_pwm ? pwm_level : cmp_level;
   wire next_pin = mode_tmr ? 1'b0 : (pin_raw ^ polarity_invert);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         timer_output_pin <= 1'b0;
      else
         timer_output_pin <= next_pin;
   end

endmodule

// *** ctm_cfg.svh ***
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define CTM_OFF_CTRL0     8'h00
`define CTM_OFF_CTRL1     8'h04
`define CTM_OFF_COUNT     8'h08
`define CTM_OFF_CMPA      8'h0C
`define CTM_OFF_STATUS    8'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define CTM_C0_PERIOD_LSB 0
`define CTM_C0_ENABLE     3
`define CTM_C0_CLKSEL_LSB 4
`define CTM_C1_CLRSEL     0
`define CTM_C1_SWAP       1
`define CTM_C1_POLINV     2
`define CTM_C1_OUTCTL     3
`define CTM_C1_ACTION_LSB 4
`define CTM_C1_MODE_LSB   6
`define CTM_ST_FLAG_A     0
`define CTM_ST_FLAG_P     1

// ==========================================================================
// Reset values and counter geometry
// ==========================================================================
`define CTM_CTRL0_RST     8'h00
`define CTM_CTRL1_RST     8'h00
`define CTM_CMPA_RST      10'h000
`define CTM_CNT_W         10
`define CTM_PER_W         3
`define CTM_PER_SHIFT     7

// ==========================================================================
// Prescaler divide counts
// ==========================================================================
`define CTM_DIV_4         6'h03
`define CTM_DIV_16        6'h0F
`define CTM_DIV_64        6'h3F

// ==========================================================================
// Bus answers
// ==========================================================================
`define CTM_RESP_OKAY     2'h0
`define CTM_RESP_SLVERR   2'h2

`endif

// *** ctm_pkg.sv ***
package ctm_pkg;

   // ==========================================================================
   // Operating modes, pin actions and timer clock selects
   // ==========================================================================
   typedef enum logic [1:0] {
      CTM_MODE_CMP   = 2'h0,
      CTM_MODE_UNDEF = 2'h1,
      CTM_MODE_PWM   = 2'h2,
      CTM_MODE_TMR   = 2'h3
   } ctm_mode_t;

   typedef enum logic [1:0] {
      CTM_ACT_HOLD   = 2'h0,
      CTM_ACT_LOW    = 2'h1,
      CTM_ACT_HIGH   = 2'h2,
      CTM_ACT_TOGGLE = 2'h3
   } ctm_action_t;

   typedef enum logic [2:0] {
      CTM_CLK_DIV4   = 3'h0,
      CTM_CLK_DIV1   = 3'h1,
      CTM_CLK_DIV16  = 3'h2,
      CTM_CLK_DIV64  = 3'h3,
      CTM_CLK_SUB_A  = 3'h4,
      CTM_CLK_SUB_B  = 3'h5,
      CTM_CLK_EXT_R  = 3'h6,
      CTM_CLK_EXT_F  = 3'h7
   } ctm_clksel_t;

endpackage

// *** ctm_axil_slave.sv ***
`timescale 1ns/10ps
`include "ctm_cfg.svh"

module ctm_axil_slave #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Register file side
   output logic                   reg_wr,
   output logic [ADDR_W-1:0]      reg_waddr,
   output logic [31:0]            reg_wdata,
   output logic [3:0]             reg_wstrb,
   input  wire logic              reg_werr,
   output logic [ADDR_W-1:0]      reg_raddr,
   input  wire logic [31:0]       reg_rdata,
   input  wire logic              reg_rerr
);

   // ==========================================================================
   // Write path: address and data are caught independently, in any order.
   // ==========================================================================
   logic aw_held;
   logic w_held;
   wire  aw_fire = s_axi_awvalid & s_axi_awready;
   wire  w_fire  = s_axi_wvalid & s_axi_wready;
   wire  b_fire  = s_axi_bvalid & s_axi_bready;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign reg_wr        = aw_held & w_held & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         reg_waddr    <= '0;
         reg_wdata    <= 32'h00000000;
         reg_wstrb    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CTM_RESP_OKAY;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_held   <= 1'b1;
            reg_waddr <= s_axi_awaddr;
         end
         if (w_fire)
         begin
            w_held    <= 1'b1;
            reg_wdata <= s_axi_wdata;
            reg_wstrb <= s_axi_wstrb;
         end
         if (reg_wr)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_werr ? `CTM_RESP_SLVERR : `CTM_RESP_OKAY;
         end
         else if (b_fire)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // Read path: data are sampled from the register file when the address is taken.
   // ==========================================================================
   assign s_axi_arready = ~s_axi_rvalid;
   assign reg_raddr     = s_axi_araddr;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `CTM_RESP_OKAY;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= reg_rerr ? 32'h00000000 : reg_rdata;
         s_axi_rresp  <= reg_rerr ? `CTM_RESP_SLVERR : `CTM_RESP_OKAY;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule

// *** ctm_timer_monitor.sv ***
`timescale 1ns/10ps
module ctm_timer_monitor (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes seen at the top ports
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
   property p_w_off; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_w_off: assert property (p_w_off) else $error("write taken while answer pending");
   property p_ar_off; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_off: assert property (p_ar_off) else $error("read taken while answer pending");
   property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("write answer repeated");
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_done: assert property (p_r_done) else $error("read answer repeated");
   property p_bresp; s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}; endproperty
   a_bresp: assert property (p_bresp) else $error("illegal write response");
endmodule

bind ctm_timer ctm_timer_monitor u_mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// *** ctm_timer_bench.sv ***
`timescale 1ns/10ps
`include "ctm_cfg.svh"
module ctm_timer_bench;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, pin;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [43:0] e;
   integer      mismatches, n_compared, i, highs;
   // Entry: ctrl1, compare A, ctrl0, high cycles in 768, status flags.
   // Every period is 256 or 128 cycles, so the 768-cycle window holds whole periods, save the compare A zero entry whose 1024-cycle overflow never moves the pin.
   localparam logic [43:0] TBL [0:12] = '{
      44'hA8_040_1A_0C0_3, 44'hAC_040_1A_240_3, 44'hA0_040_1A_240_3,
      44'hA8_12C_1A_300_2, 44'hAA_100_19_180_3, 44'hA9_040_1A_0C0_3,
      44'h98_040_1A_300_3, 44'h88_040_1A_000_3, 44'hE8_040_1A_000_3,
      44'h31_080_19_180_1, 44'h21_000_19_000_0, 44'h30_3E8_19_000_2,
      44'h28_040_1A_300_3};
   // Entry: control 0 with a divided timer clock, count expected after 256 aclk edges.
   localparam logic [15:0] DIVS [0:2] = '{16'h08_40, 16'h28_10, 16'h38_04};

   ctm_timer dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sub_clk_in(1'b0), .ext_clk_in(1'b0), .timer_output_pin(pin));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // Ready is raised only once the answer is seen, so the answer must stand a cycle.
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
      end
      while (bvalid !== 1'b1 || bready !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
      end
      while (rvalid !== 1'b1 || rready !== 1'b1);
      rready <= 1'b0;
      chk(rdata, exp);
      chk({30'h0, rresp}, {30'h0, er});
   endtask

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Roughly 13 entries of 800 cycles each; the margin covers slow answers.
   initial
   begin
      repeat (60000) @(posedge aclk);
      mismatches = mismatches + 1;
      print_verdict();
   end

   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, mismatches, n_compared} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++)
         rd(8'(i * 4), 32'h0, (i == 5) ? `CTM_RESP_SLVERR : `CTM_RESP_OKAY);
      wr(8'h14, 32'h1, `CTM_RESP_SLVERR);
      wr(`CTM_OFF_COUNT, 32'h5, `CTM_RESP_OKAY);
      rd(`CTM_OFF_COUNT, 32'h0, `CTM_RESP_OKAY);
      for (i = 0; i < 13; i++)
      begin
         e = TBL[i];
         wr(`CTM_OFF_CTRL0, 32'h0, `CTM_RESP_OKAY);
         wr(`CTM_OFF_STATUS, 32'h3, `CTM_RESP_OKAY);
         rd(`CTM_OFF_STATUS, 32'h0, `CTM_RESP_OKAY);
         wr(`CTM_OFF_CMPA, {20'h0, e[35:24]}, `CTM_RESP_OKAY);
         wr(`CTM_OFF_CTRL1, {24'h0, e[43:36]}, `CTM_RESP_OKAY);
         rd(`CTM_OFF_CMPA, {20'h0, e[35:24]}, `CTM_RESP_OKAY);
         wr(`CTM_OFF_CTRL0, {24'h0, e[23:16]}, `CTM_RESP_OKAY);
         repeat (4) @(posedge aclk);
         highs = 0;
         repeat (768)
         begin
            @(posedge aclk);
            if (pin === 1'b1) highs = highs + 1;
         end
         chk(highs, {20'h0, e[15:4]});
         rd(`CTM_OFF_STATUS, {28'h0, e[3:0]}, `CTM_RESP_OKAY);
      end
      // The write answer and the read request add two edges to the 254 waited, so the
      // counter sees 256 aclk edges; period zero keeps it from clearing in that span.
      for (i = 0; i < 3; i++)
      begin
         wr(`CTM_OFF_CTRL0, 32'h0, `CTM_RESP_OKAY);
         wr(`CTM_OFF_CTRL0, {24'h0, DIVS[i][15:8]}, `CTM_RESP_OKAY);
         repeat (254) @(posedge aclk);
         rd(`CTM_OFF_COUNT, {24'h0, DIVS[i][7:0]}, `CTM_RESP_OKAY);
      end
      print_verdict();
   end
endmodule
